// [hw/atw_pkg.sv]
package atw_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_COUNTER    = 8'h04;
   localparam logic [7:0] OFS_STATUS     = 8'h08;
   localparam logic [7:0] OFS_STAT_CLR   = 8'h0c;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h10;
   localparam logic [7:0] OFS_IRQ_DIS    = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
   localparam logic [7:0] OFS_WAKE_EN    = 8'h1c;
   localparam logic [7:0] OFS_ALARM0     = 8'h20;
   localparam logic [7:0] OFS_ALARM1     = 8'h24;
   localparam logic [7:0] OFS_PER0       = 8'h30;
   localparam logic [7:0] OFS_PER1       = 8'h34;
   localparam logic [7:0] OFS_CLK_CTRL   = 8'h40;
   localparam logic [7:0] OFS_TUNER      = 8'h44;
   localparam logic [7:0] OFS_EVT_EN     = 8'h48;
   localparam logic [7:0] OFS_EVT_DIS    = 8'h4c;
   localparam logic [7:0] OFS_EVT_MASK   = 8'h50;
   localparam logic [7:0] OFS_CALENDAR   = 8'h54;
   localparam logic [7:0] OFS_PARAM      = 8'hf0;
   localparam logic [7:0] OFS_VERSION    = 8'hfc;
   localparam logic [7:0] OFS_SLEEP_CTRL = 8'h60;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CR_EN    = 0;
   localparam int CR_PRESCALER_CLEAR  = 1;
   localparam int CR_CAL   = 2;
   localparam int CR_CA0   = 8;
   localparam int CR_PSEL  = 16;
   localparam int SR_OVF   = 0;
   localparam int SR_ALM0  = 8;
   localparam int SR_PER0  = 16;
   localparam int SR_BUSY  = 24;
   localparam int SR_READY = 25;
   localparam int DT_EXP   = 0;
   localparam int DT_ADD   = 5;
   localparam int DT_VAL   = 8;
   localparam int SL_SHUT  = 0;

   // ----------------------------------------------------------------
   // Reset values, masks and counts
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   localparam logic [31:0] CR_MASK    = 32'h001f_0307;
   localparam logic [31:0] EVT_MASK   = 32'h0003_0301;
   localparam logic [31:0] IRQ_MASK   = 32'h2203_0301;
   localparam logic [31:0] COUNT_TOP  = 32'hffff_ffff;
   localparam logic [2:0]  SYNC_COUNT = 3'h3;

   typedef struct packed {
      logic       ovf;
      logic [1:0] per;
      logic [1:0] alarm;
   } atw_evt_t;

   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } atw_req_t;

endpackage

// [hw/atw_tuner.sv]
`timescale 1ns/1ps
// Tuner: turns the prescaler clock-enable into a tuned enable by
// dropping (add=0) or inserting (add=1) one tick per period of
// ceil(256/value)*2^exp ticks.
module atw_tuner
   import atw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       tick_in,
   input  wire logic       add,
   input  wire logic [4:0] exponent,
   input  wire logic [7:0] value,
   output logic            tick_out
);
   logic [8:0]  steps;
   logic [40:0] period;
   logic [40:0] cnt_r;
   logic        extra_r;

   always_comb begin
      steps  = (value == 8'h00) ? 9'h001 :
               9'((16'd256 + 16'(value) - 16'd1) / 16'(value));
      period = 41'(steps) << exponent;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r   <= 41'h0;
         extra_r <= 1'b0;
      end else begin
         extra_r <= 1'b0;
         if (tick_in && value != 8'h00) begin
            if (cnt_r + 41'h1 >= period) begin
               cnt_r   <= 41'h0;
               extra_r <= add;
            end else begin
               cnt_r <= cnt_r + 41'h1;
            end
         end
      end
   end

   always_comb begin
      tick_out = tick_in;
      if (value != 8'h00) begin
         if (!add && tick_in && cnt_r + 41'h1 >= period) begin
            tick_out = 1'b0;
         end else if (extra_r && !tick_in) begin
            tick_out = 1'b1;
         end
      end
   end
endmodule // atw_tuner

// [hw/atw_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a level input.
module atw_sync (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // atw_sync

// [hw/atw_timer.sv]
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Periodic flag n sets when its chosen prescaler bit rises, timer on.
// - Periodic rate is source rate over two to interval_select plus one.
// - Alarm flag n sets when the running counter equals alarm value n.
// - Clear-on-alarm zeroes the counter and sets the overflow flag.
// - Five event outputs fire under the same conditions as their flags.
// - Events gated by event mask; enable sets, disable clears, zeros idle.
// - Wake-enable bits route overflow, alarm, periodic to wake output.
// - Wake stays until status-clear; meanwhile sleep requests end at once.
// - These wake sources also wake the system from shutdown.
// - Shutdown wakeup keeps all control registers but clears the mask.
// - After shutdown wakeup counter is live and status flags are kept.
// - Tuner direction zero slows the prescaler by the drop formula.
// - Tuner direction one speeds the prescaler by the insert formula.
// - Tuner value zero disables tuning; exponent must be above zero.
// - Synchronised writes set busy; busy drops writes except irq enable/disable; synced reads, bar status and event mask, give zero.
// - Synchronisation also applies with the prescaler on the bus clock.
// - Writing one to status-clear clears that flag and its request.
// - Mask bits set by irq enable writes, cleared by irq disable writes.
// - Prescaler clear bit resets the prescaler and always reads zero.
// - Counter mode wraps from all ones to zero and sets overflow.
module atw_timer
   import atw_pkg::*;
#(
   parameter logic [31:0] PARAM_VALUE   = 32'h0000_0000, // arbitrary value
   parameter logic [31:0] VERSION_VALUE = 32'h0000_0100  // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        prsc_tick,
   input  wire logic        shutdown_wake,
   input  wire logic        sleep_req,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [4:0]       irq,
   output atw_evt_t         evt,
   output logic             wake,
   output logic             sleep_abort
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_r, cnt_r, wake_en_r, clk_ctrl_r, tuner_r, cal_r;
   logic [31:0] alarm_r [2];
   logic [4:0]  interval_select_r [2];
   logic [31:0] imr_r, evm_r, sr_r, wake_flag_r;
   logic [31:0] prsc_r;
   logic [2:0]  busy_cnt_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [31:0] wmask;
   logic        tick_s, shut_s, tuned_tick, busy;
   logic        wr_ok, rd_go, wr_go;
   logic [31:0] prsc_nxt, cnt_nxt;
   logic [31:0] set_flags, clr_flags;
   logic [1:0]  per_hit, alm_hit;
   logic        ovf_hit, shut_d_r;
   atw_req_t    req;

   assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                  avs_byteenable};

   atw_sync u_sync_tick (
      .clk   (clk),
      .resetn(resetn),
      .d     (prsc_tick),
      .q     (tick_s)
   );

   atw_sync u_sync_shut (
      .clk   (clk),
      .resetn(resetn),
      .d     (shutdown_wake),
      .q     (shut_s)
   );

   atw_tuner u_tuner (
      .clk     (clk),
      .resetn  (resetn),
      .tick_in (tick_s & ctrl_r[CR_EN]),
      .add     (tuner_r[DT_ADD]),
      .exponent(tuner_r[DT_EXP +: 5]),
      .value   (tuner_r[DT_VAL +: 8]),
      .tick_out(tuned_tick)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{req.byteenable[b]}};
      end
   end

   assign busy  = (busy_cnt_r != 3'h0);
   assign rd_go = req.read && !ack_r;
   assign wr_go = req.write && !ack_r;
   assign wr_ok = wr_go && !busy;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (req.read || req.write) && !ack_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((req.read || req.write) && !ack_r);
      end
   end

   // Synchronised registers hold busy for a fixed count of clocks.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         busy_cnt_r <= 3'h0;
      end else if (wr_ok && (req.address inside {OFS_CONTROL, OFS_COUNTER,
                   OFS_STAT_CLR, OFS_WAKE_EN, OFS_EVT_EN, OFS_EVT_DIS,
                   OFS_ALARM0, OFS_ALARM1, OFS_PER0, OFS_PER1,
                   OFS_TUNER})) begin
         busy_cnt_r <= SYNC_COUNT;
      end else if (busy) begin
         busy_cnt_r <= busy_cnt_r - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_r     <= RST_ZERO;
         wake_en_r  <= RST_ZERO;
         clk_ctrl_r <= RST_ZERO;
         tuner_r    <= RST_ZERO;
         cal_r      <= RST_ZERO;
         alarm_r[0] <= RST_ZERO;
         alarm_r[1] <= RST_ZERO;
         interval_select_r[0] <= 5'h00;
         interval_select_r[1] <= 5'h00;
      end else begin
         ctrl_r[CR_PRESCALER_CLEAR] <= 1'b0;
         if (wr_ok) begin
            unique case (req.address)
               OFS_CONTROL:
                  ctrl_r <= req.writedata & wmask & CR_MASK;
               OFS_WAKE_EN:
                  wake_en_r <= req.writedata & wmask & EVT_MASK;
               OFS_CLK_CTRL: clk_ctrl_r <= req.writedata & wmask;
               OFS_TUNER:    tuner_r    <= req.writedata & wmask;
               OFS_CALENDAR: cal_r      <= req.writedata & wmask;
               OFS_ALARM0:   alarm_r[0] <= req.writedata & wmask;
               OFS_ALARM1:   alarm_r[1] <= req.writedata & wmask;
               OFS_PER0:     interval_select_r[0] <= req.writedata[4:0];
               OFS_PER1:     interval_select_r[1] <= req.writedata[4:0];
               default: ;
            endcase
         end
      end
   end

   // Masks: the interrupt mask clears on shutdown wakeup, others keep.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         imr_r <= RST_ZERO;
      end else if (shut_s && !shut_d_r) begin
         imr_r <= RST_ZERO;
      end else if (wr_go && req.address == OFS_IRQ_EN) begin
         imr_r <= imr_r | (req.writedata & IRQ_MASK);
      end else if (wr_go && req.address == OFS_IRQ_DIS) begin
         imr_r <= imr_r & ~req.writedata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         evm_r <= RST_ZERO;
      end else if (wr_ok && req.address == OFS_EVT_EN) begin
         evm_r <= evm_r | (req.writedata & EVT_MASK);
      end else if (wr_ok && req.address == OFS_EVT_DIS) begin
         evm_r <= evm_r & ~req.writedata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         shut_d_r <= 1'b0;
      end else begin
         shut_d_r <= shut_s;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and counter
   // ----------------------------------------------------------------
   always_comb begin
      prsc_nxt = prsc_r + {31'h0, tuned_tick};
      if (ctrl_r[CR_PRESCALER_CLEAR]) begin
         prsc_nxt = RST_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prsc_r <= RST_ZERO;
      end else begin
         prsc_r <= prsc_nxt;
      end
   end

   // Taps rise on a 0-to-1 step of the selected prescaler bit.
   logic cnt_rise;
   assign cnt_rise = ctrl_r[CR_EN] && !prsc_r[ctrl_r[CR_PSEL +: 5]] &&
                     prsc_nxt[ctrl_r[CR_PSEL +: 5]];

   generate
      for (genvar n = 0; n < 2; n++) begin : g_chan
         assign per_hit[n] = ctrl_r[CR_EN] && !prsc_r[interval_select_r[n]] &&
                             prsc_nxt[interval_select_r[n]];
         assign alm_hit[n] = ctrl_r[CR_EN] && cnt_rise &&
                             cnt_r == alarm_r[n];
      end
   endgenerate

   always_comb begin
      cnt_nxt = cnt_r;
      ovf_hit = 1'b0;
      if (cnt_rise) begin
         if ((alm_hit[0] && ctrl_r[CR_CA0]) ||
             (alm_hit[1] && ctrl_r[CR_CA0 + 1])) begin
            cnt_nxt = RST_ZERO;
            ovf_hit = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 32'h1;
            ovf_hit = (cnt_r == COUNT_TOP);
         end
      end
      if (wr_ok && req.address == OFS_COUNTER) begin
         cnt_nxt = req.writedata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= RST_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Status, wake, events and interrupts
   // ----------------------------------------------------------------
   always_comb begin
      set_flags = RST_ZERO;
      set_flags[SR_OVF]        = ovf_hit;
      set_flags[SR_ALM0 +: 2]  = alm_hit;
      set_flags[SR_PER0 +: 2]  = per_hit;
      clr_flags = RST_ZERO;
      if (wr_ok && req.address == OFS_STAT_CLR) begin
         clr_flags = req.writedata;
      end
   end

   // Flags survive shutdown wakeup; a set in the clear cycle wins.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sr_r <= RST_ZERO;
      end else begin
         sr_r <= (sr_r & ~clr_flags) | set_flags;
         sr_r[SR_BUSY]  <= busy;
         sr_r[SR_READY] <= (sr_r[SR_READY] & ~clr_flags[SR_READY]) |
                           (sr_r[SR_BUSY] & ~busy);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_flag_r <= RST_ZERO;
      end else begin
         wake_flag_r <= (wake_flag_r & ~clr_flags) |
                        (set_flags & wake_en_r);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake        <= 1'b0;
         sleep_abort <= 1'b0;
      end else begin
         wake        <= |wake_flag_r;
         sleep_abort <= sleep_req && (|wake_flag_r);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         evt <= '0;
      end else begin
         evt.ovf   <= ovf_hit & evm_r[SR_OVF];
         evt.alarm <= alm_hit & evm_r[SR_ALM0 +: 2];
         evt.per   <= per_hit & evm_r[SR_PER0 +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq <= 5'h00;
      end else begin
         irq[0]   <= sr_r[SR_OVF] & imr_r[SR_OVF];
         irq[2:1] <= sr_r[SR_PER0 +: 2] & imr_r[SR_PER0 +: 2];
         irq[4:3] <= sr_r[SR_ALM0 +: 2] & imr_r[SR_ALM0 +: 2];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= RST_ZERO;
      end else if (rd_go) begin
         unique case (req.address)
            OFS_CONTROL:  rdata_r <= busy ? RST_ZERO : ctrl_r;
            OFS_COUNTER:  rdata_r <= busy ? RST_ZERO : cnt_r;
            OFS_STATUS:   rdata_r <= sr_r;
            OFS_IRQ_MASK: rdata_r <= imr_r;
            OFS_WAKE_EN:  rdata_r <= busy ? RST_ZERO : wake_en_r;
            OFS_ALARM0:   rdata_r <= busy ? RST_ZERO : alarm_r[0];
            OFS_ALARM1:   rdata_r <= busy ? RST_ZERO : alarm_r[1];
            OFS_PER0:     rdata_r <= busy ? RST_ZERO : {27'h0, interval_select_r[0]};
            OFS_PER1:     rdata_r <= busy ? RST_ZERO : {27'h0, interval_select_r[1]};
            OFS_CLK_CTRL: rdata_r <= clk_ctrl_r;
            OFS_TUNER:    rdata_r <= busy ? RST_ZERO : tuner_r;
            OFS_EVT_MASK: rdata_r <= evm_r;
            OFS_CALENDAR: rdata_r <= cal_r;
            OFS_PARAM:    rdata_r <= PARAM_VALUE;
            OFS_VERSION:  rdata_r <= VERSION_VALUE;
            default:      rdata_r <= RST_ZERO;
         endcase
      end
   end

   assign avs_readdata = rdata_r;
endmodule // atw_timer

// [bench/atw_timer_sva.sv]
`timescale 1ns/1ps
module atw_chk
   import atw_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        prsc_tick,
   input wire logic        shutdown_wake,
   input wire logic        sleep_req,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [4:0]  irq,
   input wire atw_evt_t    evt,
   input wire logic        wake,
   input wire logic        sleep_abort
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------
   // Bus, event, wake and interrupt checks.
   // ------------------------------------------------------------
   a_wait_one_cycle: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one cycle");
   a_wait_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle: assert property (
      !(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer without a request");
   a_unmapped_zero: assert property (
      avs_read && avs_waitrequest && avs_address == 8'h28
      |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_abort_needs_wake: assert property (
      sleep_abort |-> wake && $past(sleep_req))
      else $error("sleep abort without wake");
   a_abort_follows: assert property (
      sleep_req ##1 wake |-> sleep_abort)
      else $error("sleep request not ended while wake high");
   a_per_pulse: assert property (
      evt.per[0] |=> !evt.per[0])
      else $error("periodic event longer than one cycle");
   a_irq_disable: assert property (
      avs_write && avs_waitrequest && avs_address == OFS_IRQ_DIS
      && avs_writedata[0] |-> ##2 !irq[0])
      else $error("overflow request stays after disable");
   a_shutdown_mask: assert property (
      $rose(shutdown_wake) |-> ##8 irq == 5'h00)
      else $error("requests stay after shutdown wakeup");
   c_abort: cover property (sleep_abort);
   c_ovf: cover property (evt.ovf);
   c_alarm: cover property (evt.alarm[0]);
endmodule // atw_chk

bind atw_timer atw_chk u_chk (
   .clk(clk), .resetn(resetn), .prsc_tick(prsc_tick),
   .shutdown_wake(shutdown_wake), .sleep_req(sleep_req),
   .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq), .evt(evt),
   .wake(wake), .sleep_abort(sleep_abort)
);

// [bench/tb.sv]
`timescale 1ns/1ps
module tb
   import atw_pkg::*;
;
   logic        clk, resetn, prsc_tick, shutdown_wake, sleep_req;
   logic [7:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest, wake, sleep_abort;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [3:0]  avs_byteenable;
   logic [4:0]  irq;
   atw_evt_t    evt;
   int          fails, samples_checked, n_ovf, n_p0, n_p1, a0, a1;
   logic [7:0]  offs [14] = '{OFS_CONTROL, OFS_COUNTER, OFS_STATUS,
      OFS_IRQ_MASK, OFS_WAKE_EN, OFS_ALARM0, OFS_ALARM1, OFS_PER0,
      OFS_PER1, OFS_TUNER, OFS_EVT_MASK, 8'h28, 8'h60, 8'h58};

   atw_timer u_dut (.clk(clk), .resetn(resetn), .prsc_tick(prsc_tick),
      .shutdown_wake(shutdown_wake), .sleep_req(sleep_req),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .evt(evt),
      .wake(wake), .sleep_abort(sleep_abort));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (evt.ovf === 1'b1) n_ovf++;
      if (evt.per[0] === 1'b1) n_p0++;
      if (evt.per[1] === 1'b1) n_p1++;
   end

   // ------------------------------------------------------------
   // Bus tasks and comparison.
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= v;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] q;
      bus(1'b1, a, v, q);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, d);
   endtask

   task automatic wait_sr(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while ((d & m) !== m && n < 400);
      if (n >= 400) fails++;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while (d[SR_BUSY] !== 1'b0 && n < 20);
      if (n >= 20) fails++;
   endtask

   task automatic wr_s(input logic [7:0] a, input logic [31:0] v);
      wait_idle();
      wr(a, v);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      end_sim();
   end

   // ------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------
   initial begin
      {resetn, prsc_tick, shutdown_wake, sleep_req} = 4'h0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      foreach (offs[i]) begin
         rd(offs[i]);
         chk("reset value", 32'h0, d);
      end
      wr(OFS_WAKE_EN, 32'h0000_0100);
      rd(OFS_STATUS);
      chk("busy flag", 32'h1, {31'h0, d[SR_BUSY]});
      wr(OFS_ALARM0, 32'h5);
      rd(OFS_ALARM0);
      chk("busy read", 32'h0, d);
      wr(OFS_ALARM1, 32'h7);
      wr(OFS_WAKE_EN, 32'h0);
      wr(OFS_IRQ_EN, 32'h0003_0301);
      wait_idle();
      rd(OFS_WAKE_EN);
      chk("dropped write", 32'h0000_0100, d);
      rd(OFS_ALARM1);
      chk("alarm1", 32'h7, d);
      rd(OFS_IRQ_MASK);
      chk("irq mask set", 32'h0003_0301, d);
      wr(OFS_IRQ_DIS, 32'h1);
      rd(OFS_IRQ_MASK);
      chk("irq mask clr", 32'h0003_0300, d);
      wr_s(OFS_EVT_EN, 32'h0003_0301);
      wr_s(OFS_EVT_DIS, 32'h1);
      wr_s(OFS_EVT_EN, 32'h0);
      wait_idle();
      rd(OFS_EVT_MASK);
      chk("event mask", 32'h0003_0300, d);
      wr_s(OFS_EVT_EN, 32'h1);
      wr(OFS_IRQ_EN, 32'h1);
      wr_s(OFS_PER1, 32'h2);
      wr_s(OFS_COUNTER, 32'hffff_fff8);
      wr_s(OFS_CONTROL, 32'h1);
      prsc_tick <= 1'b1;
      wait_sr(32'h0001_0001);
      chk("ovf irq", 32'h1, {31'h0, irq[0]});
      chk("ovf event", 32'h1, {31'h0, n_ovf > 0});
      rd(OFS_COUNTER);
      chk("wrapped", 32'h1, {31'h0, d < 32'h100});
      a0 = n_p0;
      a1 = n_p1;
      repeat (64) @(posedge clk);
      a0 = n_p0 - a0;
      a1 = n_p1 - a1;
      chk("per0 rate", 32'h1, {31'h0, a0 >= 31 && a0 <= 33});
      chk("per1 rate", 32'h1, {31'h0, a1 >= 7 && a1 <= 9});
      wr_s(OFS_CONTROL, 32'h0);
      wr_s(OFS_STAT_CLR, 32'h0003_0301);
      wait_idle();
      chk("status clr", 32'h0, d & 32'h0003_0301);
      chk("irq clr", 32'h0, {27'h0, irq});
      wr_s(OFS_ALARM0, 32'h20);
      wr_s(OFS_COUNTER, 32'h0);
      wr_s(OFS_CONTROL, 32'h0000_0101);
      wait_sr(32'h0000_0101);
      chk("wake", 32'h1, {31'h0, wake});
      sleep_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk("sleep abort", 32'h1, {31'h0, sleep_abort});
      sleep_req <= 1'b0;
      wr_s(OFS_CONTROL, 32'h0);
      wr_s(OFS_STAT_CLR, 32'h0003_0301);
      wait_idle();
      chk("wake clr", 32'h0, {31'h0, wake});
      rd(OFS_IRQ_MASK);
      chk("mask before", 32'h0003_0301, d);
      shutdown_wake <= 1'b1;
      repeat (10) @(posedge clk);
      shutdown_wake <= 1'b0;
      rd(OFS_IRQ_MASK);
      chk("mask shutdown", 32'h0, d);
      rd(OFS_WAKE_EN);
      chk("kept wake en", 32'h0000_0100, d);
      wr_s(OFS_CONTROL, 32'h0001_0102);
      wait_idle();
      rd(OFS_CONTROL);
      chk("prescaler clr", 32'h0001_0100, d);
      wr_s(OFS_TUNER, 32'h0000_8023);
      wait_idle();
      rd(OFS_TUNER);
      chk("tuner", 32'h0000_8023, d);
      end_sim();
   end
endmodule // tb
